// >>> rtl/sblc_link_core.sv
// link core: host register access, shared fifos, transmitter, receiver and cycle timer
`timescale 1ns/1ps
`include "sblc_cfg.svh"

// Summary of operation
// - a complete packet in the async transmit fifo triggers arbitration and sending.
// - isochronous transmit data waits for the next isochronous cycle before arbitration.
// - as cycle master, cycle-start packets are sent without host action.
// - receiver filters by address; crc is checked only for our packets.
// - good header goes into receive fifo, then payload one quadlet at a time.
// - a status quadlet carrying the ack code follows each received packet.
// - bad header crc drops the header and the rest of the packet.
// - received cycle-start data is forwarded to the cycle timer.
// - two transmit fifos and one receive fifo share 512 quadlets.
// - host may only write transmit fifos and only read the receive fifo.
// - only transmit fifo sizes are programmable; receive fifo gets the rest.
// - 32-bit cycle timer is readable and writable at host address 14h.
// - internal source: low 12 bits count modulo 3072 at the 24.576 MHz rate.
// - next 13 bits count 125 us cycles, top 7 bits count seconds.
// - external source: each input rising edge bumps cycle count, zeroes offset.
// - external source: a cycle output pulse follows each cycle count increment.
// - timer stops while the timer enable bit is clear.
// - internal source: offset rollover bumps cycle count and pulses cycle output.
// - non-master nodes load the timer from each received cycle-start packet.
// - cycle-start status bit is set when a cycle-start packet is sent.
// - timer rate is derived from the 49.152 MHz link clock by division.
module sblc_link_core
	import sblc_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	input  wire logic        clk_link_i,
	input  wire logic        host_cs_n_i,
	input  wire logic        host_wr_n_i,
	input  wire logic [7:0]  host_addr_i,
	input  wire logic [31:0] host_wdata_i,
	output logic      [31:0] host_rdata_o,
	output logic             host_ack_o,
	output logic             phy_arb_req_o,
	input  wire logic        phy_arb_grant_i,
	output logic             phy_tx_valid_o,
	output logic      [31:0] phy_tx_data_o,
	output logic             phy_tx_last_o,
	input  wire logic        phy_rx_valid_i,
	input  wire logic        phy_rx_sop_i,
	input  wire logic        phy_rx_eop_i,
	input  wire logic [31:0] phy_rx_data_i,
	input  wire logic        phy_rx_crc_ok_i,
	input  wire logic        external_cycle_input_i,
	output logic             cycle_output_pulse_o
);

	// ----------------------------------------------------------------
	// host side (system clock): request capture and answer
	// ----------------------------------------------------------------
	sblc_host_t  host_st_reg;
	logic        req_tgl_reg;
	logic        req_wr_reg;
	logic [7:0]  req_addr_reg;
	logic [31:0] req_wdata_reg;
	logic [2:0]  ack_sync_reg;
	logic        ack_tgl_reg;
	logic [31:0] rsp_data_reg;
	logic        ack_seen;

	assign ack_seen = ack_sync_reg[2] ^ ack_sync_reg[1];

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_sync_reg <= 3'h0;
		end else begin
			ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
		end
	end

	// request fields stay still until the answer returns, so the link side may sample them
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			host_st_reg   <= H_IDLE;
			req_tgl_reg   <= 1'b0;
			req_wr_reg    <= 1'b0;
			req_addr_reg  <= 8'h00;
			req_wdata_reg <= 32'h0000_0000;
			host_rdata_o  <= 32'h0000_0000;
			host_ack_o    <= 1'b0;
		end else begin
			host_ack_o <= 1'b0;
			case (host_st_reg)
				H_IDLE: begin
					if (!host_cs_n_i) begin
						req_wr_reg    <= ~host_wr_n_i;
						req_addr_reg  <= host_addr_i;
						req_wdata_reg <= host_wdata_i;
						req_tgl_reg   <= ~req_tgl_reg;
						host_st_reg   <= H_WAIT;
					end
				end
				H_WAIT: begin
					if (ack_seen) begin
						host_rdata_o <= rsp_data_reg;
						host_ack_o   <= 1'b1;
						host_st_reg  <= H_DONE;
					end
				end
				H_DONE: begin
					if (host_cs_n_i) begin
						host_st_reg <= H_IDLE;
					end
				end
				default: host_st_reg <= H_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// link side: register access decode
	// ----------------------------------------------------------------
	logic [2:0]  req_sync_reg;
	logic        acc;
	logic        acc_wr;
	logic        acc_rd;
	logic [15:0] node_id_reg;
	logic        master_reg;
	logic        src_reg;
	logic        cyt_en_reg;
	logic        tx_en_reg;
	logic        rx_en_reg;
	logic        cysf_reg;
	logic        hdr_err_reg;
	logic [9:0]  atq_size_reg;
	logic [9:0]  itq_size_reg;
	logic [31:0] cyt_reg;
	logic [31:0] cyt_next;
	logic [31:0] rd_val;
	logic        wr_stat;
	logic        wr_fctl;
	logic        cys_sent;
	logic        rx_cys_evt;
	logic        hdr_err_evt;

	assign acc     = req_sync_reg[2] ^ req_sync_reg[1];
	assign acc_wr  = acc & req_wr_reg;
	assign acc_rd  = acc & ~req_wr_reg;
	assign wr_stat = acc_wr && (req_addr_reg == `SBLC_ADDR_STAT);
	assign wr_fctl = acc_wr && (req_addr_reg == `SBLC_ADDR_FCTL);

	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			req_sync_reg <= 3'h0;
			ack_tgl_reg  <= 1'b0;
			rsp_data_reg <= 32'h0000_0000;
		end else begin
			req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
			if (acc) begin
				rsp_data_reg <= rd_val;
				ack_tgl_reg  <= ~ack_tgl_reg;
			end
		end
	end

	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			node_id_reg  <= `SBLC_NODE_RST;
			master_reg   <= 1'b0;
			src_reg      <= 1'b0;
			cyt_en_reg   <= 1'b0;
			tx_en_reg    <= 1'b0;
			rx_en_reg    <= 1'b0;
			atq_size_reg <= `SBLC_ATQ_SIZE_RST;
			itq_size_reg <= `SBLC_ITQ_SIZE_RST;
		end else begin
			if (acc_wr && (req_addr_reg == `SBLC_ADDR_NODE)) begin
				node_id_reg <= req_wdata_reg[31:16];
			end
			if (acc_wr && (req_addr_reg == `SBLC_ADDR_CTRL)) begin
				master_reg <= req_wdata_reg[`SBLC_CTRL_MASTER];
				src_reg    <= req_wdata_reg[`SBLC_CTRL_SRC];
				cyt_en_reg <= req_wdata_reg[`SBLC_CTRL_CYT_EN];
				tx_en_reg  <= req_wdata_reg[`SBLC_CTRL_TX_EN];
				rx_en_reg  <= req_wdata_reg[`SBLC_CTRL_RX_EN];
			end
			// a size pair that overflows the shared space is refused whole
			if (wr_fctl && ({1'b0, req_wdata_reg[19:10]} + {1'b0, req_wdata_reg[9:0]}
					<= {1'b0, `SBLC_FIFO_TOTAL})) begin
				atq_size_reg <= req_wdata_reg[19:10];
				itq_size_reg <= req_wdata_reg[9:0];
			end
		end
	end

	// status flags: a hardware set in the clearing cycle wins
	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cysf_reg    <= 1'b0;
			hdr_err_reg <= 1'b0;
		end else begin
			cysf_reg    <= cys_sent | rx_cys_evt
				| (cysf_reg & ~(wr_stat & req_wdata_reg[`SBLC_STAT_CYSF]));
			hdr_err_reg <= hdr_err_evt
				| (hdr_err_reg & ~(wr_stat & req_wdata_reg[`SBLC_STAT_HDR_ERR]));
		end
	end

	// ----------------------------------------------------------------
	// shared fifo space: atq, itq, rxq regions
	// ----------------------------------------------------------------
	logic [32:0] mem_reg [512];
	logic [9:0]  f_size [3];
	logic [9:0]  f_base [3];
	logic [8:0]  f_waddr [3];
	logic [32:0] f_din [3];
	logic [32:0] f_head [3];
	logic [2:0]  f_push;
	logic [2:0]  f_pop;
	logic [2:0]  f_clr;
	logic [2:0]  f_wen;
	logic [2:0]  f_empty;
	logic [2:0]  f_pk;
	logic        rx_push;
	logic [32:0] rx_din;
	sblc_tx_t    tx_st_reg;
	logic [1:0]  tx_sel_reg;

	assign f_size[0] = atq_size_reg;
	assign f_size[1] = itq_size_reg;
	assign f_size[2] = `SBLC_FIFO_TOTAL - atq_size_reg - itq_size_reg;
	assign f_base[0] = 10'h000;
	assign f_base[1] = atq_size_reg;
	assign f_base[2] = atq_size_reg + itq_size_reg;
	// transmit fifos take writes only, the receive fifo reads only
	assign f_push[0] = acc_wr && ((req_addr_reg == `SBLC_ADDR_ATQ)
		|| (req_addr_reg == `SBLC_ADDR_ATQ_LAST));
	assign f_push[1] = acc_wr && ((req_addr_reg == `SBLC_ADDR_ITQ)
		|| (req_addr_reg == `SBLC_ADDR_ITQ_LAST));
	assign f_push[2] = rx_push;
	assign f_din[0]  = {req_addr_reg == `SBLC_ADDR_ATQ_LAST, req_wdata_reg};
	assign f_din[1]  = {req_addr_reg == `SBLC_ADDR_ITQ_LAST, req_wdata_reg};
	assign f_din[2]  = rx_din;
	assign f_pop[0]  = (tx_st_reg == TX_SEND) && (tx_sel_reg == 2'h0);
	assign f_pop[1]  = (tx_st_reg == TX_SEND) && (tx_sel_reg == 2'h1);
	assign f_pop[2]  = acc_rd && (req_addr_reg == `SBLC_ADDR_RXQ);
	assign f_clr[0]  = wr_fctl & req_wdata_reg[`SBLC_FCTL_CLR_ATQ];
	assign f_clr[1]  = wr_fctl & req_wdata_reg[`SBLC_FCTL_CLR_ITQ];
	assign f_clr[2]  = wr_fctl & req_wdata_reg[`SBLC_FCTL_CLR_RXQ];

	genvar gi;
	for (gi = 0; gi < 3; gi++) begin : g_fifo
		logic [9:0] wp_reg;
		logic [9:0] rp_reg;
		logic [9:0] cnt_reg;
		logic [9:0] pk_reg;
		logic       do_push;
		logic       do_pop;
		logic [9:0] ra;
		logic [9:0] wa;

		// a push into a full region is dropped, a pop from an empty one does nothing
		assign do_push      = f_push[gi] && (cnt_reg != f_size[gi]);
		assign do_pop       = f_pop[gi] && (cnt_reg != 10'h000);
		assign ra           = f_base[gi] + rp_reg;
		assign wa           = f_base[gi] + wp_reg;
		assign f_waddr[gi]  = wa[8:0];
		assign f_wen[gi]    = do_push;
		assign f_head[gi]   = mem_reg[ra[8:0]];
		assign f_empty[gi]  = (cnt_reg == 10'h000);
		assign f_pk[gi]     = (pk_reg != 10'h000);

		always_ff @(posedge clk_link_i or negedge rstn_i) begin
			if (!rstn_i) begin
				wp_reg  <= 10'h000;
				rp_reg  <= 10'h000;
				cnt_reg <= 10'h000;
				pk_reg  <= 10'h000;
			end else if (f_clr[gi]) begin
				wp_reg  <= 10'h000;
				rp_reg  <= 10'h000;
				cnt_reg <= 10'h000;
				pk_reg  <= 10'h000;
			end else begin
				if (do_push) begin
					wp_reg <= (wp_reg == f_size[gi] - 10'h001) ? 10'h000 : wp_reg + 10'h001;
				end
				if (do_pop) begin
					rp_reg <= (rp_reg == f_size[gi] - 10'h001) ? 10'h000 : rp_reg + 10'h001;
				end
				cnt_reg <= cnt_reg + {9'h000, do_push} - {9'h000, do_pop};
				// count of whole packets, so the transmitter never starts a partial one
				pk_reg  <= pk_reg + {9'h000, do_push & f_din[gi][32]}
					- {9'h000, do_pop & f_head[gi][32]};
			end
		end
	end

	always_ff @(posedge clk_link_i) begin
		for (int k = 0; k < 3; k++) begin
			if (f_wen[k]) begin
				mem_reg[f_waddr[k]] <= f_din[k];
			end
		end
	end

	always_comb begin
		case (req_addr_reg)
			`SBLC_ADDR_NODE: rd_val = {node_id_reg, 16'h0000};
			`SBLC_ADDR_CTRL: rd_val = {20'h00000, master_reg, src_reg, cyt_en_reg,
				tx_en_reg, rx_en_reg, 7'h00};
			`SBLC_ADDR_STAT: rd_val = {13'h0000, cysf_reg, hdr_err_reg, f_empty[2], 16'h0000};
			`SBLC_ADDR_CYT:  rd_val = cyt_reg;
			`SBLC_ADDR_FCTL: rd_val = {12'h000, atq_size_reg, itq_size_reg};
			`SBLC_ADDR_RXQ:  rd_val = f_empty[2] ? 32'h0000_0000 : f_head[2][31:0];
			default:         rd_val = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	logic        cys_due_reg;
	logic        iso_open_reg;
	logic        cyc_inc;
	logic [32:0] tx_head;

	assign tx_head  = (tx_sel_reg == 2'h1) ? f_head[1] : f_head[0];
	assign cys_sent = (tx_st_reg == TX_CYS_DATA);

	// a due cycle start or an opened isochronous window survives a same-cycle clear
	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cys_due_reg  <= 1'b0;
			iso_open_reg <= 1'b0;
		end else begin
			cys_due_reg  <= (cyc_inc & master_reg) | (cys_due_reg & ~cys_sent);
			iso_open_reg <= cys_sent | rx_cys_evt
				| (iso_open_reg & ~((tx_st_reg == TX_IDLE) & ~f_pk[1]));
		end
	end

	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_st_reg      <= TX_IDLE;
			tx_sel_reg     <= 2'h0;
			phy_arb_req_o  <= 1'b0;
			phy_tx_valid_o <= 1'b0;
			phy_tx_data_o  <= 32'h0000_0000;
			phy_tx_last_o  <= 1'b0;
		end else begin
			phy_tx_valid_o <= 1'b0;
			phy_tx_last_o  <= 1'b0;
			case (tx_st_reg)
				TX_IDLE: begin
					if (cys_due_reg) begin
						tx_sel_reg    <= 2'h2;
						phy_arb_req_o <= 1'b1;
						tx_st_reg     <= TX_ARB;
					end else if (tx_en_reg && iso_open_reg && f_pk[1]) begin
						tx_sel_reg    <= 2'h1;
						phy_arb_req_o <= 1'b1;
						tx_st_reg     <= TX_ARB;
					end else if (tx_en_reg && f_pk[0]) begin
						tx_sel_reg    <= 2'h0;
						phy_arb_req_o <= 1'b1;
						tx_st_reg     <= TX_ARB;
					end
				end
				TX_ARB: begin
					if (phy_arb_grant_i) begin
						phy_arb_req_o <= 1'b0;
						tx_st_reg     <= (tx_sel_reg == 2'h2) ? TX_CYS_HDR : TX_SEND;
					end
				end
				TX_SEND: begin
					phy_tx_valid_o <= 1'b1;
					phy_tx_data_o  <= tx_head[31:0];
					phy_tx_last_o  <= tx_head[32];
					if (tx_head[32]) begin
						tx_st_reg <= TX_IDLE;
					end
				end
				TX_CYS_HDR: begin
					phy_tx_valid_o <= 1'b1;
					phy_tx_data_o  <= `SBLC_CYS_HEADER;
					tx_st_reg      <= TX_CYS_DATA;
				end
				TX_CYS_DATA: begin
					phy_tx_valid_o <= 1'b1;
					phy_tx_data_o  <= cyt_reg;
					phy_tx_last_o  <= 1'b1;
					tx_st_reg      <= TX_IDLE;
				end
				default: tx_st_reg <= TX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	sblc_rx_t rx_st_reg;
	logic     rx_cys_reg;
	logic [3:0] rx_ack_reg;
	logic     rx_for_us;
	logic     rx_hdr;
	logic     rx_good_hdr;

	assign rx_for_us = (phy_rx_data_i[7:4] == `SBLC_TCODE_ISO)
		|| (phy_rx_data_i[31:16] == node_id_reg)
		|| (phy_rx_data_i[21:16] == `SBLC_BCAST_PHY);
	assign rx_hdr      = (rx_st_reg == RX_IDLE) && phy_rx_valid_i && phy_rx_sop_i && rx_en_reg;
	assign rx_good_hdr = rx_hdr && rx_for_us && phy_rx_crc_ok_i;
	assign hdr_err_evt = rx_hdr && rx_for_us && !phy_rx_crc_ok_i;
	assign rx_cys_evt  = (rx_st_reg == RX_BODY) && phy_rx_valid_i && rx_cys_reg;
	assign rx_push     = rx_good_hdr || (rx_st_reg == RX_STAT)
		|| ((rx_st_reg == RX_BODY) && phy_rx_valid_i);
	assign rx_din      = (rx_st_reg == RX_STAT) ? {1'b1, 28'h0000000, rx_ack_reg}
		: {1'b0, phy_rx_data_i};

	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_st_reg  <= RX_IDLE;
			rx_cys_reg <= 1'b0;
			rx_ack_reg <= 4'h0;
		end else begin
			case (rx_st_reg)
				RX_IDLE: begin
					if (rx_good_hdr) begin
						rx_cys_reg <= (phy_rx_data_i[7:4] == `SBLC_TCODE_CYS);
						rx_ack_reg <= `SBLC_ACK_COMPLETE;
						rx_st_reg  <= phy_rx_eop_i ? RX_STAT : RX_BODY;
					end else if (rx_hdr && !phy_rx_eop_i) begin
						rx_st_reg <= RX_DROP;
					end
				end
				RX_BODY: begin
					if (phy_rx_valid_i) begin
						rx_cys_reg <= 1'b0;
						if (phy_rx_eop_i) begin
							rx_ack_reg <= phy_rx_crc_ok_i ? `SBLC_ACK_COMPLETE
								: `SBLC_ACK_DATA_ERR;
							rx_st_reg  <= RX_STAT;
						end
					end
				end
				RX_STAT: rx_st_reg <= RX_IDLE;
				RX_DROP: begin
					if (phy_rx_valid_i && phy_rx_eop_i) begin
						rx_st_reg <= RX_IDLE;
					end
				end
				default: rx_st_reg <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// cycle timer
	// ----------------------------------------------------------------
	logic [2:0]  cin_sync_reg;
	logic        cin_lvl_reg;
	logic        ext_rise;
	logic [3:0]  div_cnt_reg;
	logic        tick;
	logic        cyt_load;
	logic [12:0] cyc_nxt;
	logic [6:0]  sec_nxt;

	// the input counts as changed only once the two later stages agree
	assign ext_rise = (cin_sync_reg[2] == cin_sync_reg[1]) & cin_sync_reg[2] & ~cin_lvl_reg;
	assign tick     = (div_cnt_reg == 4'(`SBLC_TICK_DIV - 1));
	assign cyt_load = (acc_wr && (req_addr_reg == `SBLC_ADDR_CYT))
		|| (rx_cys_evt && !master_reg);
	assign cyc_inc  = !cyt_load && cyt_en_reg && (src_reg ? ext_rise
		: (tick && (cyt_reg[11:0] == `SBLC_OFFSET_MAX)));
	assign cyc_nxt  = (cyt_reg[24:12] == `SBLC_CYCLE_MAX) ? 13'h0000
		: cyt_reg[24:12] + 13'h0001;
	assign sec_nxt  = (cyt_reg[24:12] == `SBLC_CYCLE_MAX) ? cyt_reg[31:25] + 7'h01
		: cyt_reg[31:25];

	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// an unused input is tied high, so starting high avoids a false edge
			cin_sync_reg <= 3'h7;
			cin_lvl_reg  <= 1'b1;
			div_cnt_reg  <= 4'h0;
		end else begin
			cin_sync_reg <= {cin_sync_reg[1:0], external_cycle_input_i};
			if (cin_sync_reg[2] == cin_sync_reg[1]) begin
				cin_lvl_reg <= cin_sync_reg[2];
			end
			div_cnt_reg <= tick ? 4'h0 : div_cnt_reg + 4'h1;
		end
	end

	always_comb begin
		cyt_next = cyt_reg;
		if (acc_wr && (req_addr_reg == `SBLC_ADDR_CYT)) begin
			cyt_next = req_wdata_reg;
		end else if (rx_cys_evt && !master_reg) begin
			cyt_next = phy_rx_data_i;
		end else if (cyc_inc) begin
			cyt_next = {sec_nxt, cyc_nxt, 12'h000};
		end else if (cyt_en_reg && !src_reg && tick) begin
			cyt_next = {cyt_reg[31:12], cyt_reg[11:0] + 12'h001};
		end
	end

	// a clear enable bit freezes every field, including the external path
	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cyt_reg              <= 32'h0000_0000;
			cycle_output_pulse_o <= 1'b0;
		end else begin
			cyt_reg              <= cyt_next;
			cycle_output_pulse_o <= cyc_inc;
		end
	end

endmodule

// >>> rtl/sblc_cfg.svh
// offsets, field positions, reset values and timing counts of the serial-bus link core
`ifndef SBLC_CFG_SVH
`define SBLC_CFG_SVH

// ----------------------------------------------------------------
// register offsets on the host bus
// ----------------------------------------------------------------
`define SBLC_ADDR_NODE      8'h04
`define SBLC_ADDR_CTRL      8'h08
`define SBLC_ADDR_STAT      8'h0C
`define SBLC_ADDR_CYT       8'h14
`define SBLC_ADDR_FCTL      8'h1C
`define SBLC_ADDR_ATQ       8'h80
`define SBLC_ADDR_ATQ_LAST  8'h84
`define SBLC_ADDR_ITQ       8'h88
`define SBLC_ADDR_ITQ_LAST  8'h8C
`define SBLC_ADDR_RXQ       8'hC0

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SBLC_CTRL_MASTER    11
`define SBLC_CTRL_SRC       10
`define SBLC_CTRL_CYT_EN    9
`define SBLC_CTRL_TX_EN     8
`define SBLC_CTRL_RX_EN     7
`define SBLC_STAT_CYSF      18
`define SBLC_STAT_HDR_ERR   17
`define SBLC_STAT_RXQ_EMPTY 16
`define SBLC_FCTL_CLR_ATQ   31
`define SBLC_FCTL_CLR_ITQ   30
`define SBLC_FCTL_CLR_RXQ   29
`define SBLC_NODE_RST       16'hFFFF
`define SBLC_ATQ_SIZE_RST   10'h080
`define SBLC_ITQ_SIZE_RST   10'h080

// ----------------------------------------------------------------
// fifo space, packet codes, timer limits
// ----------------------------------------------------------------
`define SBLC_FIFO_TOTAL     10'h200
`define SBLC_TCODE_CYS      4'h8
`define SBLC_TCODE_ISO      4'hA
`define SBLC_BCAST_PHY      6'h3F
`define SBLC_ACK_COMPLETE   4'h1
`define SBLC_ACK_DATA_ERR   4'hD
`define SBLC_CYS_HEADER     32'hFFFF0080
`define SBLC_OFFSET_MAX     12'hBFF
`define SBLC_CYCLE_MAX      13'h1F3F
`define SBLC_LINK_KHZ       49152
`define SBLC_TIMER_KHZ      24576
`define SBLC_TICK_DIV       ((`SBLC_LINK_KHZ) / (`SBLC_TIMER_KHZ))

`endif

// >>> rtl/sblc_pkg.sv
// state types of the serial-bus link core
package sblc_pkg;
	typedef enum logic [1:0] {H_IDLE, H_WAIT, H_DONE} sblc_host_t;
	typedef enum logic [2:0] {TX_IDLE, TX_ARB, TX_SEND, TX_CYS_HDR, TX_CYS_DATA} sblc_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_BODY, RX_STAT, RX_DROP} sblc_rx_t;
endpackage

// >>> dv/sblc_link_core_chk.sv
// port timing checker of the serial-bus link core
`timescale 1ns/1ps
module sblc_link_core_chk (
	input wire logic        clk_sys_i,
	input wire logic        rstn_i,
	input wire logic        clk_link_i,
	input wire logic        host_ack_o,
	input wire logic [31:0] host_rdata_o,
	input wire logic        phy_arb_req_o,
	input wire logic        phy_arb_grant_i,
	input wire logic        phy_tx_valid_o,
	input wire logic [31:0] phy_tx_data_o,
	input wire logic        phy_tx_last_o,
	input wire logic        cycle_output_pulse_o
);
	ack_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		host_ack_o |=> !host_ack_o) else $error("ack too long");
	rdata_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!host_ack_o |-> $stable(host_rdata_o)) else $error("read data moved");
	req_hold_a: assert property (@(posedge clk_link_i) disable iff (!rstn_i)
		phy_arb_req_o && !phy_arb_grant_i |=> phy_arb_req_o) else $error("request dropped");
	grant_send_a: assert property (@(posedge clk_link_i) disable iff (!rstn_i)
		phy_arb_req_o && phy_arb_grant_i |-> ##2 phy_tx_valid_o) else $error("no data after grant");
	last_valid_a: assert property (@(posedge clk_link_i) disable iff (!rstn_i)
		phy_tx_last_o |-> phy_tx_valid_o) else $error("last without valid");
	last_end_a: assert property (@(posedge clk_link_i) disable iff (!rstn_i)
		phy_tx_last_o |=> !phy_tx_valid_o) else $error("data after last");
	cys_pair_a: assert property (@(posedge clk_link_i) disable iff (!rstn_i)
		phy_tx_valid_o && !phy_tx_last_o && phy_tx_data_o == 32'hFFFF_0080
		|=> phy_tx_valid_o && phy_tx_last_o) else $error("cycle start length");
	pulse_gap_a: assert property (@(posedge clk_link_i) disable iff (!rstn_i)
		cycle_output_pulse_o |=> !cycle_output_pulse_o [*8]) else $error("pulses too close");
	tx_cov: cover property (@(posedge clk_link_i) phy_tx_last_o);
	pulse_cov: cover property (@(posedge clk_link_i) cycle_output_pulse_o);
	ack_cov: cover property (@(posedge clk_sys_i) host_ack_o);
endmodule

bind sblc_link_core sblc_link_core_chk sblc_link_core_chk_inst (.*);

// >>> dv/sblc_phy_model.sv
// serial-bus phy stand-in: grants arbitration, logs sent quadlets, sends packets
`timescale 1ns/1ps
module sblc_phy_model (
	input  wire logic        clk_link_i,
	input  wire logic        arb_req_i,
	output logic             arb_grant_o,
	input  wire logic        tx_valid_i,
	input  wire logic [31:0] tx_data_i,
	output logic             rx_valid_o,
	output logic             rx_sop_o,
	output logic             rx_eop_o,
	output logic      [31:0] rx_data_o,
	output logic             rx_crc_ok_o
);
	int          grant_wait = 1;
	int          n_tx = 0;
	logic [31:0] seen [16];
	initial {arb_grant_o, rx_valid_o, rx_sop_o, rx_eop_o, rx_crc_ok_o, rx_data_o} = '0;
	always @(negedge clk_link_i) if (tx_valid_i === 1'b1 && n_tx < 16) begin
		seen[n_tx] = tx_data_i;
		n_tx++;
	end
	// grant comes grant_wait cycles late and lasts one cycle
	always @(negedge clk_link_i) if (arb_req_i === 1'b1) begin
		repeat (grant_wait) @(negedge clk_link_i);
		arb_grant_o = 1'b1;
		@(negedge clk_link_i);
		arb_grant_o = 1'b0;
	end
	// released data lines show the inverse of the last quadlet, not a stale copy
	task automatic send(input logic [31:0] hdr, body, input logic hok, dok);
		@(negedge clk_link_i);
		{rx_valid_o, rx_sop_o, rx_crc_ok_o, rx_data_o} = {2'b11, hok, hdr};
		@(negedge clk_link_i);
		{rx_sop_o, rx_eop_o, rx_crc_ok_o, rx_data_o} = {2'b01, dok, body};
		@(negedge clk_link_i);
		{rx_valid_o, rx_eop_o, rx_crc_ok_o, rx_data_o} = {3'b000, ~body};
		repeat (4) @(negedge clk_link_i);
	endtask
endmodule

// >>> dv/sblc_link_core_bench.sv
// self-checking bench of the serial-bus link core
`timescale 1ns/1ps
`include "sblc_cfg.svh"
module sblc_link_core_bench;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;} sblc_row_t;
	logic        clk_sys_i = 0, clk_link_i = 0, rstn_i = 0, host_cs_n_i = 1, host_wr_n_i = 1;
	logic        external_cycle_input_i = 0, host_ack_o, phy_arb_req_o, phy_arb_grant_i;
	logic        phy_tx_valid_o, phy_tx_last_o, phy_rx_valid_i, phy_rx_sop_i, phy_rx_eop_i;
	logic        phy_rx_crc_ok_i, cycle_output_pulse_o;
	logic [7:0]  host_addr_i = 8'h00;
	logic [31:0] host_wdata_i = '0, host_rdata_o, phy_tx_data_o, phy_rx_data_i, rd;
	int          fails = 0, n_compared = 0, i;
	sblc_row_t   rows [10] = '{
		'{1'b1, `SBLC_ADDR_NODE, 32'h0012_0000, '0},
		'{1'b0, `SBLC_ADDR_NODE, '0, 32'h0012_0000},
		'{1'b1, `SBLC_ADDR_FCTL, 32'hE001_90C8, '0},
		'{1'b1, `SBLC_ADDR_FCTL, 32'h0004_B12C, '0},
		'{1'b0, `SBLC_ADDR_FCTL, '0, 32'h0001_90C8},
		'{1'b0, `SBLC_ADDR_ATQ, '0, '0},
		'{1'b0, `SBLC_ADDR_STAT, '0, 32'h0001_0000},
		'{1'b0, 8'h40, '0, '0},
		'{1'b1, `SBLC_ADDR_CYT, 32'h01F3_FBF0, '0},
		'{1'b0, `SBLC_ADDR_CYT, '0, 32'h01F3_FBF0}};
	logic [31:0] rxq [7] = '{32'h0012_0010, 32'h3, 32'hD, 32'hFFFF_0080, 32'h0AB0_0123,
		32'h1, 32'h0};
	sblc_link_core sblc_link_core_inst (.*);
	sblc_phy_model sblc_phy_model_inst (.clk_link_i, .arb_req_i(phy_arb_req_o),
		.arb_grant_o(phy_arb_grant_i), .tx_valid_i(phy_tx_valid_o), .tx_data_i(phy_tx_data_o),
		.rx_valid_o(phy_rx_valid_i), .rx_sop_o(phy_rx_sop_i), .rx_eop_o(phy_rx_eop_i),
		.rx_data_o(phy_rx_data_i), .rx_crc_ok_o(phy_rx_crc_ok_i));
	always #2.5 clk_sys_i = ~clk_sys_i;
	always #16 clk_link_i = ~clk_link_i;
	task automatic end_of_test();
		$display("compared %0d, wrong %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		int k;
		for (k = 0; k < lim && s !== 1'b1; k++) @(negedge clk_sys_i);
		if (k == lim) begin
			fails++;
			end_of_test();
		end
	endtask
	// cs stays low through the edge that samples ack, then high for a cycle
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_sys_i);
		{host_cs_n_i, host_wr_n_i, host_addr_i, host_wdata_i} = {1'b0, !w, a, d};
		wait_hi(host_ack_o, 200);
		rd = host_rdata_o;
		@(negedge clk_sys_i);
		host_cs_n_i = 1'b1;
		@(negedge clk_sys_i);
	endtask
	initial begin
		repeat (12) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		acc(1'b0, `SBLC_ADDR_CYT, '0);
		chk("timer reset", 32'h0, rd);
		for (i = 0; i < 10; i++) begin
			acc(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk("register", rows[i].e, rd);
		end
		$display("register test done");
		acc(1'b1, `SBLC_ADDR_CTRL, 32'h0000_0200);
		wait_hi(cycle_output_pulse_o, 4000);
		acc(1'b0, `SBLC_ADDR_CYT, '0);
		chk("second wrap", 32'h0200_0000, rd & 32'hFFFF_F000);
		acc(1'b1, `SBLC_ADDR_CYT, 32'h0200_0800);
		acc(1'b1, `SBLC_ADDR_CTRL, 32'h0000_0600);
		external_cycle_input_i = 1'b1;
		wait_hi(cycle_output_pulse_o, 100);
		acc(1'b0, `SBLC_ADDR_CYT, '0);
		external_cycle_input_i = 1'b0;
		chk("external edge", 32'h0200_1000, rd & 32'hFFFF_FFC0);
		$display("timer test done");
		acc(1'b1, `SBLC_ADDR_CTRL, 32'h0000_0100);
		sblc_phy_model_inst.grant_wait = 5;
		acc(1'b1, `SBLC_ADDR_ATQ, 32'h1234_0010);
		acc(1'b1, `SBLC_ADDR_ATQ_LAST, 32'h5A5A_A5A5);
		wait_hi(phy_tx_last_o, 400);
		repeat (10) @(negedge clk_sys_i);
		chk("async count", 32'h2, sblc_phy_model_inst.n_tx);
		chk("async data", 32'h5A5A_A5A5, sblc_phy_model_inst.seen[1]);
		sblc_phy_model_inst.n_tx = 0;
		sblc_phy_model_inst.grant_wait = 0;
		acc(1'b1, `SBLC_ADDR_ITQ, 32'h0000_00A0);
		acc(1'b1, `SBLC_ADDR_ITQ_LAST, 32'hC3C3_3C3C);
		acc(1'b1, `SBLC_ADDR_CYT, 32'h0000_0BF0);
		acc(1'b1, `SBLC_ADDR_CTRL, 32'h0000_0B00);
		for (i = 0; i < 2000 && sblc_phy_model_inst.n_tx < 4; i++) @(negedge clk_sys_i);
		if (sblc_phy_model_inst.n_tx < 4) begin
			fails++;
			end_of_test();
		end
		chk("cycle start", 32'hFFFF_0080, sblc_phy_model_inst.seen[0]);
		chk("iso after start", 32'h0000_00A0, sblc_phy_model_inst.seen[2]);
		chk("iso last", 32'hC3C3_3C3C, sblc_phy_model_inst.seen[3]);
		$display("transmit test done");
		acc(1'b1, `SBLC_ADDR_CTRL, 32'h0000_0280);
		sblc_phy_model_inst.send(32'h0034_0010, 32'h2, 1'b0, 1'b1);
		acc(1'b0, `SBLC_ADDR_STAT, '0);
		chk("foreign packet", 32'h0005_0000, rd & 32'h0007_0000);
		sblc_phy_model_inst.send(32'h0012_0010, 32'h2, 1'b0, 1'b1);
		sblc_phy_model_inst.send(32'h0012_0010, 32'h3, 1'b1, 1'b0);
		sblc_phy_model_inst.send(32'hFFFF_0080, 32'h0AB0_0123, 1'b1, 1'b1);
		for (i = 0; i < 7; i++) begin
			acc(1'b0, `SBLC_ADDR_RXQ, '0);
			chk("receive fifo", rxq[i], rd);
		end
		acc(1'b0, `SBLC_ADDR_STAT, '0);
		chk("bad header", 32'h0007_0000, rd & 32'h0007_0000);
		acc(1'b0, `SBLC_ADDR_CYT, '0);
		chk("loaded timer", 32'h0000_AB00, rd >> 12);
		$display("receive test done");
		@(negedge clk_sys_i);
		rstn_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		acc(1'b0, `SBLC_ADDR_NODE, '0);
		chk("node after reset", {`SBLC_NODE_RST, 16'h0000}, rd);
		$display("reset test done");
		end_of_test();
	end
endmodule
